/* design/ilo_pkg.sv */
// Constants, register map and field layout of the indexed operand decoder
package ilo_pkg;
    localparam int ILO_AW = 12;              // Data address width
    localparam int ILO_BW = 4;               // Bank select width
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_WREG   = 8'h04;
    localparam logic [7:0] OFS_SFP    = 8'h08;
    localparam logic [7:0] OFS_BSR    = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_INSTR  = 8'h14;
    localparam logic [7:0] OFS_EA     = 8'h18;
    localparam logic [7:0] OFS_PC     = 8'h1C;
    localparam logic [7:0] OFS_TOS    = 8'h20;
    localparam logic [7:0] OFS_MADDR  = 8'h24;
    localparam logic [7:0] OFS_MDATA  = 8'h28;
    // Field positions
    localparam int BIT_XINST = 0;
    localparam int BIT_BUSY  = 16;
    localparam int BIT_IDX   = 16;
    localparam int FLG_C  = 0;
    localparam int FLG_DC = 1;
    localparam int FLG_Z  = 2;
    localparam int FLG_OV = 3;
    localparam int FLG_N  = 4;
    // Opcode patterns and limits
    localparam logic [5:0] OPC_ADD_HI = 6'h09;   // 0010 01xx
    localparam logic [9:0] OPC_SUB_HI = 10'h3A7; // 1110 1001 11xx
    localparam logic [7:0] IDX_LIMIT  = 8'h5F;
    localparam logic [ILO_BW-1:0] ACC_LO_BANK = 4'h0;
    localparam logic [ILO_BW-1:0] ACC_HI_BANK = 4'hF;
    // Responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_NOP  = 2'b10
    } ilo_state_t;
endpackage : ilo_pkg

/* design/ilo_dec_if.sv */
// Carrier between the core and the operand address decoder
`timescale 1ns/100ps
interface ilo_dec_if;
    import ilo_pkg::*;
    logic              xinst;
    logic [7:0]        farg;
    logic              acc_sel;
    logic [ILO_AW-1:0] sfp;
    logic [ILO_BW-1:0] bank_select_register;
    logic [ILO_AW-1:0] ea;
    logic              indexed;
    modport core (output xinst, farg, acc_sel, sfp, bank_select_register,
                  input ea, indexed);
    modport dec  (input xinst, farg, acc_sel, sfp, bank_select_register,
                  output ea, indexed);
endinterface : ilo_dec_if

/* design/ilo_addr_dec.sv */
// Operand effective address decoder, literal or frame-pointer relative
`timescale 1ns/100ps
module ilo_addr_dec
    import ilo_pkg::*;
(
    ilo_dec_if.dec d
);
    logic [ILO_BW-1:0] acc_bank;

    // indexed mode gate
    // Indexed only in extended mode, access bank, small argument
    assign d.indexed = d.xinst && !d.acc_sel && (d.farg <= IDX_LIMIT);
    // Access arguments up to 5Fh sit in bank 0, those above in the top bank
    assign acc_bank = (d.farg <= IDX_LIMIT) ? ACC_LO_BANK : ACC_HI_BANK;

    // literal or pointer-relative address
    // Address select
    always_comb begin
        if (d.indexed) begin
            d.ea = d.sfp + {{(ILO_AW-8){1'b0}}, d.farg};
        end else if (d.acc_sel) begin
            d.ea = {d.bank_select_register, d.farg};
        end else begin
            d.ea = {acc_bank, d.farg};
        end
    end
endmodule : ilo_addr_dec

/* design/ilo_core.sv */
// Indexed literal offset core: AXI4-Lite registers, decode and execute
// Contract
// - Extended mode turns on frame-relative decoding, else it is off.
// - Non-extended addresses are literal, access bank or bank select.
// - Extended, access bit clear, argument up to 5Fh adds the pointer.
// - A zero frame pointer makes indexed addresses equal literal ones.
// - Indexed add sums W and memory byte and sets N, OV, C, DC, Z.
// - Destination bit 0 writes W, 1 writes the memory byte back.
// - Indexed add decodes from 0010 01d0 kkkk kkkk in one cycle.
// - Pointer subtract and return takes two cycles, second is idle.
`timescale 1ns/100ps
module ilo_core
    import ilo_pkg::*;
#(
    parameter int MEM_BYTES = 4096
)(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    if (MEM_BYTES < (1 << ILO_AW)) begin : g_chk
        $error("MEM_BYTES must cover the data address space");
    end

    typedef struct packed {
        logic              aw_held;
        logic [7:0]        awaddr;
        logic              w_held;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic              xinst;
        logic [7:0]        wreg;
        logic [ILO_AW-1:0] sfp;
        logic [ILO_BW-1:0] bank_select_register;
        logic [4:0]        status;
        logic [15:0]       opcode;
        logic [ILO_AW-1:0] ea;
        logic              ea_idx;
        logic [15:0]       pc;
        logic [15:0]       return_stack_top;
        logic [ILO_AW-1:0] mem_addr;
        ilo_state_t        st;
    } ilo_regs_t;

    ilo_regs_t         s;
    ilo_regs_t         next_s;
    logic [7:0]        mem [MEM_BYTES];
    logic              mem_we;
    logic [ILO_AW-1:0] mem_wa;
    logic [7:0]        mem_wd;
    logic [7:0]        opnd;
    logic [8:0]        sum;
    logic [4:0]        lo_sum;
    logic              is_add;
    logic              is_sub;
    logic              ovf;
    logic [7:0]        ra;
    ilo_dec_if         dbus ();

    // Byte-lane merge of a bus write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // Decoder fed from the latched opcode
    assign dbus.xinst   = s.xinst;
    assign dbus.farg    = s.opcode[7:0];
    assign dbus.acc_sel = s.opcode[8];
    assign dbus.sfp     = s.sfp;
    assign dbus.bank_select_register     = s.bank_select_register;

    ilo_addr_dec u_dec (
        .d (dbus.dec)
    );

    assign is_add = (s.opcode[15:10] == OPC_ADD_HI);
    assign is_sub = (s.opcode[15:6] == OPC_SUB_HI);
    // sum, nibble carry and signed wrap
    assign opnd   = mem[dbus.ea];
    assign sum    = {1'b0, s.wreg} + {1'b0, opnd};
    assign lo_sum = {1'b0, s.wreg[3:0]} + {1'b0, opnd[3:0]};
    assign ovf    = (s.wreg[7] == opnd[7]) && (sum[7] != s.wreg[7]);
    assign ra     = s_axi_araddr[7:0];

    // Handshake outputs; data outputs come from the state
    assign s_axi_awready = !s.aw_held;
    assign s_axi_wready  = !s.w_held;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rdata   = s.rdata;
    assign s_axi_rresp   = s.rresp;

    // Next state: bus slave, then execution, which wins on conflicts
    always_comb begin
        logic [31:0] m;
        m      = '0;
        next_s = s;
        mem_we = 1'b0;
        mem_wa = s.mem_addr;
        mem_wd = s.wdata[7:0];
        if (s_axi_awvalid && !s.aw_held) begin
            next_s.aw_held = 1'b1;
            next_s.awaddr  = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && !s.w_held) begin
            next_s.w_held = 1'b1;
            next_s.wdata  = s_axi_wdata;
            next_s.wstrb  = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        // Write only once both halves are in and the last answer is gone
        if (s.aw_held && s.w_held && !s.bvalid) begin
            next_s.aw_held = 1'b0;
            next_s.w_held  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = RESP_OKAY;
            case (s.awaddr)
                OFS_CTRL: begin
                    m = merge({31'h0000_0000, s.xinst}, s.wdata, s.wstrb);
                    next_s.xinst = m[BIT_XINST];
                end
                OFS_WREG: begin
                    m = merge({24'h00_0000, s.wreg}, s.wdata, s.wstrb);
                    next_s.wreg = m[7:0];
                end
                OFS_SFP: begin
                    m = merge({20'h0_0000, s.sfp}, s.wdata, s.wstrb);
                    next_s.sfp = m[ILO_AW-1:0];
                end
                OFS_BSR: begin
                    m = merge({28'h000_0000, s.bank_select_register}, s.wdata, s.wstrb);
                    next_s.bank_select_register = m[ILO_BW-1:0];
                end
                OFS_STATUS: begin
                    m = merge({27'h000_0000, s.status}, s.wdata, s.wstrb);
                    next_s.status = m[4:0];
                end
                OFS_INSTR: begin
                    // Ignored while an instruction is still running
                    if (s.st == ST_IDLE) begin
                        m = merge({16'h0000, s.opcode}, s.wdata, s.wstrb);
                        next_s.opcode = m[15:0];
                        next_s.st     = ST_EXEC;
                    end
                end
                OFS_EA: begin
                end
                OFS_PC: begin
                    m = merge({16'h0000, s.pc}, s.wdata, s.wstrb);
                    next_s.pc = m[15:0];
                end
                OFS_TOS: begin
                    m = merge({16'h0000, s.return_stack_top}, s.wdata, s.wstrb);
                    next_s.return_stack_top = m[15:0];
                end
                OFS_MADDR: begin
                    m = merge({20'h0_0000, s.mem_addr}, s.wdata, s.wstrb);
                    next_s.mem_addr = m[ILO_AW-1:0];
                end
                OFS_MDATA: begin
                    mem_we = s.wstrb[0];
                end
                default: begin
                    next_s.bresp = RESP_SLVERR;
                end
            endcase
        end
        // Register reads, one cycle after the address is taken
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = RESP_OKAY;
            next_s.rdata  = 32'h0000_0000;
            case (ra)
                OFS_CTRL:   next_s.rdata[BIT_XINST] = s.xinst;
                OFS_WREG:   next_s.rdata[7:0] = s.wreg;
                OFS_SFP:    next_s.rdata[ILO_AW-1:0] = s.sfp;
                OFS_BSR:    next_s.rdata[ILO_BW-1:0] = s.bank_select_register;
                OFS_STATUS: next_s.rdata[4:0] = s.status;
                OFS_INSTR: begin
                    next_s.rdata[15:0]     = s.opcode;
                    next_s.rdata[BIT_BUSY] = (s.st != ST_IDLE);
                end
                OFS_EA: begin
                    next_s.rdata[ILO_AW-1:0] = s.ea;
                    next_s.rdata[BIT_IDX]    = s.ea_idx;
                end
                OFS_PC:     next_s.rdata[15:0] = s.pc;
                OFS_TOS:    next_s.rdata[15:0] = s.return_stack_top;
                OFS_MADDR:  next_s.rdata[ILO_AW-1:0] = s.mem_addr;
                OFS_MDATA:  next_s.rdata[7:0] = mem[s.mem_addr];
                default:    next_s.rresp = RESP_SLVERR;
            endcase
        end
        // Execution sequencer
        case (s.st)
            ST_IDLE: begin
            end
            ST_EXEC: begin
                // every opcode latches its decoded address
                next_s.ea     = dbus.ea;
                next_s.ea_idx = dbus.indexed;
                next_s.st     = ST_IDLE;
                if (is_add) begin
                    next_s.status[FLG_C]  = sum[8];
                    next_s.status[FLG_DC] = lo_sum[4];
                    next_s.status[FLG_Z]  = (sum[7:0] == 8'h00);
                    next_s.status[FLG_OV] = ovf;
                    next_s.status[FLG_N]  = sum[7];
                    if (s.opcode[9]) begin
                        mem_we = 1'b1;
                        mem_wa = dbus.ea;
                        mem_wd = sum[7:0];
                    end else begin
                        next_s.wreg = sum[7:0];
                    end
                end else if (is_sub) begin
                    // pointer minus literal, return from stack top
                    next_s.sfp = s.sfp - {{(ILO_AW-6){1'b0}}, s.opcode[5:0]};
                    next_s.pc  = s.return_stack_top;
                    next_s.st  = ST_NOP;
                end
            end
            ST_NOP: begin
                next_s.st = ST_IDLE;
            end
            default: next_s.st = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Data memory, not reset: contents are undefined after power-up
    always_ff @(posedge aclk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_sub_go;
        s.st == ST_EXEC && is_sub;
    endsequence
    sequence s_sub_tail;
        ##1 s.st == ST_NOP ##1 s.st == ST_IDLE;
    endsequence

    a_ext_off_literal: assert property (!s.xinst |-> !dbus.indexed)
        else $error("indexed decode active with extension off");
    a_bank_select_addr: assert property (
        !s.xinst && s.opcode[8] |-> dbus.ea == {s.bank_select_register, s.opcode[7:0]})
        else $error("banked literal address wrong");
    a_frame_offset_add: assert property (
        s.xinst && !s.opcode[8] && s.opcode[7:0] <= IDX_LIMIT
        |-> dbus.indexed &&
            dbus.ea == s.sfp + {4'h0, s.opcode[7:0]})
        else $error("indexed address not pointer plus offset");
    a_high_arg_literal: assert property (
        s.xinst && (s.opcode[8] || s.opcode[7:0] > IDX_LIMIT)
        |-> !dbus.indexed)
        else $error("large argument decoded as indexed");
    a_zero_ptr_map: assert property (
        s.xinst && s.sfp == 12'h000 && !s.opcode[8]
        |-> dbus.ea[7:0] == s.opcode[7:0])
        else $error("zero pointer map differs from literal map");
    a_add_zero_flag: assert property (
        s.st == ST_EXEC && is_add
        |=> s.status[FLG_Z] == ($past(sum[7:0]) == 8'h00)
            && s.status[FLG_C] == $past(sum[8]))
        else $error("add flags wrong");
    a_add_to_wreg: assert property (
        s.st == ST_EXEC && is_add && !s.opcode[9]
        |=> s.wreg == $past(sum[7:0]))
        else $error("add result missing from W");
    a_add_one_cycle: assert property (
        s.st == ST_EXEC && is_add |=> s.st == ST_IDLE)
        else $error("indexed add did not finish in one cycle");
    a_sub_two_cycle: assert property (
        s_sub_go |-> s_sub_tail)
        else $error("pointer subtract and return timing wrong");
endmodule : ilo_core

/* bench/ilo_prog_rom.sv */
// Instruction fetch model: the opcode words fed to the core
`timescale 1ns/100ps
module ilo_prog_rom (
    input  wire logic [1:0]  idx,
    output logic      [15:0] word
);
    // Fixed program stream; idle slot fetches an all-zero word
    always_comb begin
        case (idx)
            // add to indexed, result to W
            2'd0: word = 16'h242C;
            // add to indexed, result to memory
            2'd1: word = 16'h262C;
            2'd2: word = 16'hE9E3;
            default: word = 16'h0000;
        endcase
    end
endmodule : ilo_prog_rom

/* bench/ilo_core_tb.sv */
// Self-checking bench for the indexed operand decoder core
`timescale 1ns/100ps
module ilo_core_tb;
    import ilo_pkg::*;
    typedef struct {
        logic [15:0] ctrl, sfp, bank_select_register, op;
        logic [31:0] ea;
    } ilo_row_t;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, pidx, resp;
    logic [15:0] pword;
    logic [31:0] rdat;
    int          bad_count, checks_done;
    ilo_row_t    rows [8];

    ilo_core #(.MEM_BYTES(4096)) i_dut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    ilo_prog_rom i_rom (.idx(pidx), .word(pword));

    // 40 MHz clock
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    // Write cycle: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr  <= {24'h00_0000, a};
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 100);
        r = s_axi_bresp;
        if (n >= 100) bad_count++;
    endtask : wr

    // Read cycle; rready stays high for the whole run
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr  <= {24'h00_0000, a};
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 100);
        d = s_axi_rdata;
        r = s_axi_rresp;
        if (n >= 100) bad_count++;
    endtask : rd

    task automatic put(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask : put

    task automatic get(input logic [7:0] a, output logic [31:0] d);
        logic [1:0] r;
        rd(a, d, r);
        chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask : get

    // Poll busy with a bound; a stuck core counts as a mismatch
    task automatic idle;
        logic [31:0] d;
        int n;
        n = 0;
        do begin
            get(OFS_INSTR, d);
            n++;
        end while (d[BIT_BUSY] !== 1'b0 && n < 20);
        if (n >= 20) bad_count++;
    endtask : idle

    // Indexed add at frame pointer + 2Ch; checks W, memory byte, flags
    task automatic add_case(input logic [1:0] i,
                            input logic [7:0] wv, mv, ew, em, es);
        logic [31:0] d;
        pidx = i;
        @(posedge aclk);
        put(OFS_WREG, {24'h00_0000, wv});
        put(OFS_MADDR, 32'h0000_0A2C);
        put(OFS_MDATA, {24'h00_0000, mv});
        put(OFS_INSTR, {16'h0000, pword});
        idle();
        get(OFS_WREG, d);
        chk("wreg", {24'h00_0000, ew}, d);
        get(OFS_MDATA, d);
        chk("mem", {24'h00_0000, em}, d);
        get(OFS_STATUS, d);
        chk("status", {24'h00_0000, es}, d);
        get(OFS_EA, d);
        chk("ea", 32'h0001_0A2C, d);
    endtask : add_case

    // Watchdog well beyond the expected run length
    initial begin
        #500000;
        bad_count++;
        final_report();
    end

    // Main sequence
    initial begin
        aresetn = 1'b0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b1;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b1;
        s_axi_awaddr = 32'h0000_0000;
        s_axi_araddr = 32'h0000_0000;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        pidx = 2'd0;
        bad_count = 0;
        checks_done = 0;
        rows = '{
            '{16'h0000, 16'h0A00, 16'h0005, 16'h6A20, 32'h0000_0020},
            '{16'h0000, 16'h0A00, 16'h0005, 16'h6A80, 32'h0000_0F80},
            '{16'h0000, 16'h0A00, 16'h0005, 16'h6B20, 32'h0000_0520},
            '{16'h0001, 16'h0A00, 16'h0003, 16'h6A5F, 32'h0001_0A5F},
            '{16'h0001, 16'h0A00, 16'h0003, 16'h6A60, 32'h0000_0F60},
            '{16'h0001, 16'h0A00, 16'h0003, 16'h6B10, 32'h0000_0310},
            '{16'h0001, 16'h0000, 16'h0003, 16'h6A30, 32'h0001_0030},
            '{16'h0001, 16'h0FF0, 16'h0003, 16'h6A20, 32'h0001_0010}};
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        get(OFS_CTRL, rdat);
        chk("ctrl reset", 32'h0000_0000, rdat);
        get(OFS_STATUS, rdat);
        chk("status reset", 32'h0000_0000, rdat);
        $display("test reset done");
        // Decode table: literal, banked, indexed, boundary, zero pointer
        foreach (rows[i]) begin
            put(OFS_CTRL, {16'h0000, rows[i].ctrl});
            put(OFS_SFP, {16'h0000, rows[i].sfp});
            put(OFS_BSR, {16'h0000, rows[i].bank_select_register});
            put(OFS_INSTR, {16'h0000, rows[i].op});
            idle();
            get(OFS_EA, rdat);
            chk("ea", rows[i].ea, rdat);
        end
        $display("test decode table done");
        // Unmapped read and write to the read-only address register
        rd(8'h30, rdat, resp);
        chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        chk("unmapped data", 32'h0000_0000, rdat);
        put(OFS_EA, 32'hFFFF_FFFF);
        get(OFS_EA, rdat);
        chk("ea read only", 32'h0001_0010, rdat);
        $display("test refusals done");
        // Indexed add: plain, carries, zero result, sign overflow
        put(OFS_CTRL, 32'h0000_0001);
        put(OFS_SFP, 32'h0000_0A00);
        add_case(2'd0, 8'h17, 8'h20, 8'h37, 8'h20, 8'h00);
        add_case(2'd1, 8'h88, 8'h88, 8'h88, 8'h10, 8'h0B);
        add_case(2'd1, 8'h01, 8'hFF, 8'h01, 8'h00, 8'h07);
        add_case(2'd0, 8'h70, 8'h10, 8'h80, 8'h10, 8'h18);
        $display("test indexed add done");
        // Pointer subtract and return; the idle cycle leaves W alone
        put(OFS_SFP, 32'h0000_03FF);
        put(OFS_PC, 32'h0000_0100);
        put(OFS_TOS, 32'h0000_0123);
        pidx = 2'd2;
        @(posedge aclk);
        put(OFS_INSTR, {16'h0000, pword});
        idle();
        get(OFS_SFP, rdat);
        chk("sfp", 32'h0000_03DC, rdat);
        get(OFS_PC, rdat);
        chk("pc", 32'h0000_0123, rdat);
        get(OFS_WREG, rdat);
        chk("wreg kept", 32'h0000_0080, rdat);
        $display("test subtract return done");
        final_report();
    end
endmodule : ilo_core_tb
